/* include/pie_pkg.sv */
// Package for the peripheral interrupt enable and request flag block.
// Assumes an APB slave with 32-bit data; registers occupy the low byte of a word.
package pie_pkg;

  // ****************************************
  // Register map and layout
  // ****************************************
  localparam int          PIE_NSRC        = 8;
  localparam int          PIE_AW          = 12;
  localparam logic [11:0] PIE_FLAGS_ADDR  = 12'h00C;
  localparam logic [11:0] PIE_ENABLE_ADDR = 12'h08C;
  localparam logic [11:0] PIE_MASK_ADDR   = 12'h100;
  localparam logic [7:0]  PIE_FLAGS_RST   = 8'h00;
  localparam logic [7:0]  PIE_ENABLE_RST  = 8'h00;
  localparam logic [7:0]  PIE_MASK_RST    = 8'h00;
  localparam logic [31:0] PIE_UNMAPPED    = 32'h0000_0000;

  // Source bit positions
  localparam int PIE_BIT_EEPROM = 7;
  localparam int PIE_BIT_ADC    = 6;
  localparam int PIE_BIT_CCP    = 5;
  localparam int PIE_BIT_CMPB   = 4;
  localparam int PIE_BIT_CMPA   = 3;
  localparam int PIE_BIT_OSC    = 2;
  localparam int PIE_BIT_TMRB   = 1;
  localparam int PIE_BIT_TMRA   = 0;

  // Core control gates that arrive from outside this block
  typedef struct packed {
    logic global_irq_enable;
    logic peripheral_group_enable;
  } pie_core_ctl_t;

  // APB request bundle
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [PIE_AW-1:0] paddr;
    logic [31:0]       pwdata;
    logic [3:0]        pstrb;
  } pie_apb_req_t;

endpackage

/* rtl/pie_flags.sv */
// Peripheral interrupt enable and request flag registers behind an APB slave.
// Assumes source event pulses are synchronous to clk_sys, one cycle per event.
`timescale 1ns/1ns

// Overview of operation
// - An eight-bit enable register at 0x8C, reset to zero, holds one enable per source.
// - An eight-bit flag register at 0x0C, reset to zero, holds one flag per source, same positions.
// - No source raises periph_irq_req unless the peripheral group enable is set as well as its own enable; irq uses only irq_mask.
// - A flag sets on its event regardless of its enable and of the global enable.
// - Enable bit 1 lets the timer B period match interrupt through, zero blocks it.
// - Enable bit 0 lets the timer A overflow interrupt through, zero blocks it.
// - Flag bit 7 sets on a completed EEPROM write and stays set until software clears it.
// - Flag bit 0 sets on timer A overflow and stays set until software clears it.
module pie_flags
  import pie_pkg::*;
#(
  parameter int NSRC = PIE_NSRC
) (
  // Clock, reset, enable
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  input  wire logic              clk_en,
  // APB slave
  input  wire pie_apb_req_t      apb_req,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Source event pulses, bit order as the flag register
  input  wire logic [NSRC-1:0]   src_event,
  // Core control gates
  input  wire pie_core_ctl_t     core_ctl,
  // Interrupt outputs
  output logic                   periph_irq_req,
  output logic                   irq
);

  // ****************************************
  // Registers and decode
  // ****************************************
  logic [NSRC-1:0] peripheral_request_flags;
  logic [NSRC-1:0] peripheral_request_enables;
  logic [NSRC-1:0] irq_mask;
  logic [NSRC-1:0] next_flags;
  logic            wr_fire;
  logic            rd_fire;
  logic            hit_flags;
  logic            hit_enable;
  logic            hit_mask;
  logic            lane0;

  // One wait state: the access fires in the first access cycle, pready is asserted in the second
  assign wr_fire    = apb_req.psel & apb_req.penable & apb_req.pwrite & ~pready;
  assign rd_fire    = apb_req.psel & apb_req.penable & ~apb_req.pwrite & ~pready;
  assign hit_flags  = apb_req.paddr == PIE_FLAGS_ADDR;
  assign hit_enable = apb_req.paddr == PIE_ENABLE_ADDR;
  assign hit_mask   = apb_req.paddr == PIE_MASK_ADDR;
  assign lane0      = apb_req.pstrb[0];

  // ****************************************
  // Flag update, one bit per source
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_flag
      always_comb begin
        next_flags[g] = peripheral_request_flags[g];
        if (wr_fire && hit_flags && lane0) begin
          next_flags[g] = apb_req.pwdata[g];
        end
        if (src_event[g]) begin
          next_flags[g] = 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      peripheral_request_flags <= PIE_FLAGS_RST;
    end else if (clk_en) begin
      peripheral_request_flags <= next_flags;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      peripheral_request_enables <= PIE_ENABLE_RST;
    end else if (clk_en && wr_fire && hit_enable && lane0) begin
      peripheral_request_enables <= apb_req.pwdata[NSRC-1:0];
    end
  end

  // Mask for the bus-level interrupt line; separate from the enables so software
  // can poll the core request without raising the system line
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irq_mask <= PIE_MASK_RST;
    end else if (clk_en && wr_fire && hit_mask && lane0) begin
      irq_mask <= apb_req.pwdata[NSRC-1:0];
    end
  end

  // ****************************************
  // Interrupt outputs
  // ****************************************
  // Group enable gates all sources
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      periph_irq_req <= 1'b0;
    end else if (clk_en) begin
      periph_irq_req <= core_ctl.peripheral_group_enable &
                        (|(next_flags & peripheral_request_enables));
    end
  end

  // System line, level high while any unmasked flag is set
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(next_flags & irq_mask);
    end
  end

  // ****************************************
  // APB answer
  // ****************************************
  // One wait state: the access is taken at the first penable edge and pready
  // follows one cycle later. The ~pready term in the fire strobes keeps a long
  // access phase from writing twice. Unmapped reads return zero with no error,
  // which keeps old drivers that probe the map from faulting the core.
  // prdata holds its value between reads so a slow master still sees it.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pready  <= 1'b0;
      prdata  <= PIE_UNMAPPED;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready  <= apb_req.psel & apb_req.penable & ~pready;
      pslverr <= 1'b0;
      if (rd_fire) begin
        if (hit_flags) begin
          prdata <= {{(32-NSRC){1'b0}}, peripheral_request_flags};
        end else if (hit_enable) begin
          prdata <= {{(32-NSRC){1'b0}}, peripheral_request_enables};
        end else if (hit_mask) begin
          prdata <= {{(32-NSRC){1'b0}}, irq_mask};
        end else begin
          prdata <= PIE_UNMAPPED;
        end
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  flag_set_a: assert property (clk_en && src_event[0] |=> peripheral_request_flags[0])
    else $error("event did not set its flag");
  flag_sticky_a: assert property (clk_en && peripheral_request_flags[0] && !(wr_fire && hit_flags)
    |=> peripheral_request_flags[0])
    else $error("flag cleared without software");
  set_wins_a: assert property (clk_en && src_event[1] && wr_fire && hit_flags && lane0
    && !apb_req.pwdata[1] |=> peripheral_request_flags[1])
    else $error("write beat the event");
  group_gate_a: assert property (clk_en && !core_ctl.peripheral_group_enable
    |=> !periph_irq_req)
    else $error("request without group enable");
  timer_b_a: assert property (clk_en && core_ctl.peripheral_group_enable
    && next_flags == 8'h02 && peripheral_request_enables == 8'h02 |=> periph_irq_req)
    else $error("timer B match not raised");
  timer_a_a: assert property (clk_en && next_flags == 8'h01
    && peripheral_request_enables[0] == 1'b0 && (peripheral_request_enables & 8'hFE) == 8'h00
    |=> !periph_irq_req)
    else $error("timer A overflow not blocked");
  enable_reg_a: assert property (clk_en && wr_fire && hit_enable && lane0
    |=> peripheral_request_enables == $past(apb_req.pwdata[NSRC-1:0]))
    else $error("enable write lost");
  eeprom_rd_a: assert property (clk_en && rd_fire && hit_flags
    |=> prdata[PIE_BIT_EEPROM] == $past(peripheral_request_flags[PIE_BIT_EEPROM]))
    else $error("eeprom flag readback wrong");
  req_or_a: assert property (clk_en |=> periph_irq_req == ($past(core_ctl.peripheral_group_enable)
    && |($past(next_flags) & $past(peripheral_request_enables))))
    else $error("request not OR of flag and enable");
  flag_clr_a: assert property (clk_en && wr_fire && hit_flags && lane0 && !src_event[2]
    |=> peripheral_request_flags[2] == $past(apb_req.pwdata[2]))
    else $error("flag write lost");

  pready_pulse_a: assert property (clk_en && pready |=> !pready)
    else $error("pready stood for more than one cycle");
  slverr_zero_a: assert property (!pslverr)
    else $error("error response raised");
  upper_zero_a: assert property (prdata[31:NSRC] == '0)
    else $error("upper read bits not zero");
  irq_level_a: assert property (clk_en |=> irq == (|($past(next_flags) & $past(irq_mask))))
    else $error("system line not OR of flag and mask");
  enable_hold_a: assert property (clk_en && !(wr_fire && hit_enable && lane0)
    |=> $stable(peripheral_request_enables))
    else $error("enables changed without a write");
  // EEPROM flag rises only on its event or a write
  eeprom_quiet_a: assert property (clk_en && !peripheral_request_flags[PIE_BIT_EEPROM]
    && !src_event[PIE_BIT_EEPROM] && !(wr_fire && hit_flags && lane0)
    |=> !peripheral_request_flags[PIE_BIT_EEPROM])
    else $error("eeprom flag set with no write done");

  // ****************************************
  // Per-source checks
  // ****************************************
  // Every source sets its own flag
  generate
    for (g = 0; g < NSRC; g++) begin : g_chk
      src_set_a: assert property (clk_en && src_event[g] |=> peripheral_request_flags[g])
        else $error("source event did not set its flag");
      src_hold_a: assert property (clk_en && peripheral_request_flags[g]
        && !(wr_fire && hit_flags && lane0) |=> peripheral_request_flags[g])
        else $error("flag cleared by hardware");
      // Frozen enable must hold the flag even if the event pulse is lost
      frozen_a: assert property (!clk_en
        |=> peripheral_request_flags[g] == $past(peripheral_request_flags[g]))
        else $error("flag moved while frozen");
    end
  endgenerate

  irq_seen_c:  cover property (periph_irq_req);
  freeze_c:    cover property (!clk_en && |src_event);
  clash_c:     cover property (src_event[0] && wr_fire && hit_flags);
  sys_irq_c:   cover property (irq);
  unmapped_c:  cover property (rd_fire && !hit_flags && !hit_enable && !hit_mask);

endmodule

/* bench/test_peripheral_interrupt_enable_flags.sv */
// Bench for the peripheral enable and request flag block.
// Assumes the one wait state APB slave and registered outputs of pie_flags.
`timescale 1ns/1ns
module test_peripheral_interrupt_enable_flags
  import pie_pkg::*;
;
  // ****************************************
  // Stimulus signals
  // ****************************************
  logic          clk_sys = 1'b0;
  logic          nrst = 1'b0;
  logic          en = 1'b1;
  pie_apb_req_t  req = '0;
  logic [7:0]    ev = 8'h00;
  pie_core_ctl_t ctl = '0;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic          preq;
  logic          irq;
  logic [31:0]   rd;
  int            fail_count = 0;
  int            tests_run = 0;
  int            cyc = 0;

  pie_flags DUT (.clk_sys(clk_sys), .nrst(nrst), .clk_en(en), .apb_req(req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_event(ev),
    .core_ctl(ctl), .periph_irq_req(preq), .irq(irq));

  // Free running 100 MHz clock
  always #5 clk_sys = ~clk_sys;

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic end_sim();
    $display("Checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Cut a hang short; the tests need well under a thousand cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      fail_count++;
    end
  endtask

  // One APB transfer; e pulses sources in the cycle the write lands
  task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d,
                     input logic [7:0] e, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_sys);
    req.psel <= 1'b1;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= {24'h000000, d};
    req.pstrb <= 4'hF;
    @(posedge clk_sys);
    req.penable <= 1'b1;
    ev <= e;
    // Values read right after an edge are the ones sampled at it
    do begin
      @(posedge clk_sys);
      ev <= 8'h00;
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(a, 1'b1, d, 8'h00, rd);
  endtask

  task automatic rdchk(input string nm, input logic [11:0] a, input logic [7:0] x);
    apb(a, 1'b0, 8'h00, 8'h00, rd);
    check(nm, rd, {24'h000000, x});
    check("slverr", pslverr, 1'b0);
  endtask

  // Pulse sources, then let the flag and the request settle
  task automatic pulse(input logic [7:0] e);
    @(posedge clk_sys);
    ev <= e;
    repeat (3) @(posedge clk_sys);
    ev <= 8'h00;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    rdchk("flags_rst", PIE_FLAGS_ADDR, PIE_FLAGS_RST);
    rdchk("enables_rst", PIE_ENABLE_ADDR, PIE_ENABLE_RST);
    wr(PIE_ENABLE_ADDR, 8'hA5);
    rdchk("enables_rw", PIE_ENABLE_ADDR, 8'hA5);
    wr(PIE_FLAGS_ADDR, 8'h5A);
    rdchk("flags_rw", PIE_FLAGS_ADDR, 8'h5A);
    wr(PIE_FLAGS_ADDR, 8'h00);
    wr(PIE_ENABLE_ADDR, 8'h00);
    $display("test regs done");
  endtask

  // Events with every enable and both core gates off, then sticky
  task automatic t_events();
    pulse(8'h81);
    repeat (4) @(posedge clk_sys);
    rdchk("flags_set", PIE_FLAGS_ADDR, 8'h81);
    check("req_off", preq, 1'b0);
    $display("test events done");
  endtask

  // Enable bits and the group gate decide the request
  task automatic t_gate();
    wr(PIE_ENABLE_ADDR, 8'h02);
    ctl.peripheral_group_enable <= 1'b1;
    repeat (2) @(posedge clk_sys);
    check("req_tmrb_off", preq, 1'b0);
    ctl.peripheral_group_enable <= 1'b0;
    wr(PIE_ENABLE_ADDR, 8'h01);
    repeat (2) @(posedge clk_sys);
    check("req_group_off", preq, 1'b0);
    ctl.peripheral_group_enable <= 1'b1;
    repeat (2) @(posedge clk_sys);
    check("req_tmra", preq, 1'b1);
    wr(PIE_FLAGS_ADDR, 8'h00);
    @(posedge clk_sys);
    check("req_cleared", preq, 1'b0);
    wr(PIE_ENABLE_ADDR, 8'h02);
    pulse(8'h02);
    check("req_tmrb", preq, 1'b1);
    $display("test gate done");
  endtask

  // A source event beats a clearing write at the same edge
  task automatic t_race();
    apb(PIE_FLAGS_ADDR, 1'b1, 8'h00, 8'h10, rd);
    rdchk("flags_race", PIE_FLAGS_ADDR, 8'h10);
    $display("test race done");
  endtask

  task automatic t_mask();
    wr(PIE_MASK_ADDR, 8'h10);
    @(posedge clk_sys);
    check("irq_on", irq, 1'b1);
    wr(PIE_FLAGS_ADDR, 8'h00);
    @(posedge clk_sys);
    check("irq_off", irq, 1'b0);
    rdchk("unmapped", 12'h200, 8'h00);
    $display("test mask done");
  endtask

  // Frozen enable drops events, then a reset in mid-run clears everything
  task automatic t_freeze();
    @(posedge clk_sys);
    en <= 1'b0;
    ev <= 8'h08;
    repeat (2) @(posedge clk_sys);
    ev <= 8'h00;
    en <= 1'b1;
    rdchk("flags_frozen", PIE_FLAGS_ADDR, 8'h00);
    pulse(8'h08);
    rdchk("flags_cmpa", PIE_FLAGS_ADDR, 8'h08);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    rdchk("enables_rerst", PIE_ENABLE_ADDR, PIE_ENABLE_RST);
    rdchk("flags_rerst", PIE_FLAGS_ADDR, PIE_FLAGS_RST);
    $display("test freeze done");
  endtask

  initial begin
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    t_regs();
    t_events();
    t_gate();
    t_race();
    t_mask();
    t_freeze();
    end_sim();
  end
endmodule
